// [core/alarm_channel.sv]
// Purpose: High and low alarm state of one sensor input.
// Assumes: valid is a one-cycle strobe per new reading.
// Notes:   A reset command arriving with a new reading loses to the set.
`timescale 1ns/1ps
`include "alarm_defs.svh"

module alarm_channel #(
    parameter int W = `ALM_VALUE_W
) (
    input logic        core_clk,
    input logic        reset,
    alarm_eval_if.chan bus
);

    logic signed [W:0] rd_x;
    logic signed [W:0] hs_x;
    logic signed [W:0] ls_x;
    logic signed [W:0] hs_rel;
    logic signed [W:0] ls_rel;
    logic              hi_set;
    logic              hi_hold;
    logic              lo_set;
    logic              lo_hold;
    logic              high_q;
    logic              low_q;

    // Widen by one bit so the deadband offsets cannot wrap.
    assign rd_x    = {bus.reading[W-1], bus.reading};
    assign hs_x    = {bus.high_sp[W-1], bus.high_sp};
    assign ls_x    = {bus.low_sp[W-1], bus.low_sp};
    assign hs_rel  = hs_x - {bus.deadband[W-1], bus.deadband};
    assign ls_rel  = ls_x + {bus.deadband[W-1], bus.deadband};
    assign hi_set  = rd_x > hs_x;
    assign hi_hold = rd_x > hs_rel;
    assign lo_set  = rd_x < ls_x;
    assign lo_hold = rd_x < ls_rel;

    // High alarm state, updated on a new reading, cleared when disabled or by a latched reset.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            high_q <= `ALM_FLAG_RST;
        end else if (!bus.en) begin
            high_q <= 1'b0;
        end else if (bus.valid) begin
            if (bus.latch) begin
                high_q <= hi_set | (high_q & ~bus.clr);
            end else begin
                high_q <= high_q ? hi_hold : hi_set;
            end
        end else if (bus.clr && bus.latch) begin
            high_q <= 1'b0;
        end
    end

    // Low alarm state, mirror of the high side.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            low_q <= `ALM_FLAG_RST;
        end else if (!bus.en) begin
            low_q <= 1'b0;
        end else if (bus.valid) begin
            if (bus.latch) begin
                low_q <= lo_set | (low_q & ~bus.clr);
            end else begin
                low_q <= low_q ? lo_hold : lo_set;
            end
        end else if (bus.clr && bus.latch) begin
            low_q <= 1'b0;
        end
    end

    assign bus.high = high_q;
    assign bus.low  = low_q;

endmodule : alarm_channel

// [core/alarm_defs.svh]
// Purpose: Shared constants for the input alarm monitor.
// Assumes: Core clock of 125 MHz.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef ALARM_DEFS_SVH
`define ALARM_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define ALM_NUM_INPUTS    8
`define ALM_VALUE_W       32
`define ALM_SRC_W         2

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define ALM_FLAG_RST      1'b0
`define ALM_CLK_MHZ       125
`define ALM_CONFIRM_MS    1000
`define ALM_FLASH_HALF_MS 250
`define ALM_CONFIRM_CYC   (`ALM_CONFIRM_MS * `ALM_CLK_MHZ * 1000)
`define ALM_FLASH_CYC     (`ALM_FLASH_HALF_MS * `ALM_CLK_MHZ * 1000)

`endif

// [core/alarm_eval_if.sv]
// Purpose: Carries one input's reading and settings to its evaluator.
// Assumes: One instance per sensor input.
// Notes:   Values are signed fixed point in the selected source's units.
`timescale 1ns/1ps

interface alarm_eval_if #(
    parameter int W = 32
);
    logic                valid;
    logic signed [W-1:0] reading;
    logic                en;
    logic                latch;
    logic signed [W-1:0] high_sp;
    logic signed [W-1:0] low_sp;
    logic signed [W-1:0] deadband;
    logic                clr;
    logic                high;
    logic                low;

    modport ctrl (
        output valid, reading, en, latch, high_sp, low_sp, deadband, clr,
        input  high, low
    );

    modport chan (
        input  valid, reading, en, latch, high_sp, low_sp, deadband, clr,
        output high, low
    );
endinterface : alarm_eval_if

// [core/alarm_pkg.sv]
// Purpose: Types for the input alarm monitor.
// Assumes: Nothing beyond the constants header.
// Notes:   The source encoding follows declaration order.
package alarm_pkg;

    // Reading source used for the alarm comparison.
    typedef enum logic [1:0] {
        SRC_KELVIN,
        SRC_CELSIUS,
        SRC_SENSOR,
        SRC_LINEAR
    } src_t;

    // States of the reset confirmation display.
    typedef enum logic {
        CONFIRM_IDLE,
        CONFIRM_SHOW
    } confirm_state_t;

endpackage : alarm_pkg

// [core/input_alarm_monitor.sv]
// Purpose: Alarm evaluation, indicators and beeper for eight inputs.
// Assumes: One reading strobe names the input and carries all sources.
// Notes:   Flash and confirmation times are parameters for simulation.
`timescale 1ns/1ps
`include "alarm_defs.svh"

// Operation
// - Each of eight inputs has its own high and low alarm settings.
// - High alarm asserts when the selected reading exceeds high setpoint.
// - Low alarm asserts when the selected reading is below low setpoint.
// - Source per input: Kelvin, Celsius, raw sensor, or linear result.
// - A disabled input is not evaluated and its alarms stay off.
// - An input's display location flashes while any of its alarms is on.
// - Annunciator steady when any input enabled, flashing when any active.
// - Annunciator covers every input, displayed or not.
// - High alarm, unlatched, releases at setpoint minus deadband.
// - Deadband serves non-latching alarms only; zero means no hysteresis.
// - A latched alarm stays on after its cause ends until reset.
// - A non-latching alarm clears itself once its condition ends.
// - Global audible setting: beep while any alarm is on, else silent.
// - Reset clears latched alarms; a lasting condition returns next update.
// - Reset leaves non-latching alarms as they are.
// - Accepted reset shows a brief confirmation before normal display.
// - Setpoints and deadband hold five significant digits, source units.
// - Reset stays accepted even while the keypad is locked.
module input_alarm_monitor #(
    parameter int N             = `ALM_NUM_INPUTS,
    parameter int W             = `ALM_VALUE_W,
    parameter int FLASH_CYCLES   = `ALM_FLASH_CYC,
    parameter int CONFIRM_CYCLES = `ALM_CONFIRM_CYC
) (
    input  logic                   core_clk,
    input  logic                   reset,
    input  logic                   rd_valid,
    input  logic [$clog2(N)-1:0]   rd_chan,
    input  logic signed [W-1:0]    rd_kelvin,
    input  logic signed [W-1:0]    rd_celsius,
    input  logic signed [W-1:0]    rd_sensor,
    input  logic signed [W-1:0]    rd_linear,
    input  logic [N-1:0]           alarm_en,
    input  logic [N-1:0]           latch_en,
    input  logic [2*N-1:0]         src_sel,
    input  logic [N*W-1:0]         high_sp,
    input  logic [N*W-1:0]         low_sp,
    input  logic [N*W-1:0]         deadband,
    input  logic                   audible_en,
    input  logic                   alarm_reset_cmd,
    output logic [N-1:0]           high_alarm,
    output logic [N-1:0]           low_alarm,
    output logic [N-1:0]           loc_flash,
    output logic                   annun_lit,
    output logic                   beeper,
    output logic                   reset_confirm
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                          flash_phase_q;
    logic [31:0]                   flash_cnt_q;
    logic [31:0]                   confirm_cnt_q;
    alarm_pkg::confirm_state_t     confirm_state_q;
    logic [N-1:0]                  active;
    logic                          any_active;
    logic                          any_enabled;
    logic [N-1:0]                  loc_flash_q;
    logic                          annun_q;
    logic                          beeper_q;
    logic signed [W-1:0]           sel_value;
    logic signed [W:0]             cur_hs;
    logic signed [W:0]             cur_ls;
    logic signed [W:0]             cur_db;

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------

    // Picks the reading that an input compares against its setpoints.
    function automatic logic signed [W-1:0] select_source(
        input logic [1:0]          sel,
        input logic signed [W-1:0] k,
        input logic signed [W-1:0] c,
        input logic signed [W-1:0] s,
        input logic signed [W-1:0] l
    );
        case (alarm_pkg::src_t'(sel))
            alarm_pkg::SRC_KELVIN:  select_source = k;
            alarm_pkg::SRC_CELSIUS: select_source = c;
            alarm_pkg::SRC_SENSOR:  select_source = s;
            default:                select_source = l;
        endcase
    endfunction : select_source

    // The strobed input's own source choice picks the value.
    assign sel_value = select_source(src_sel[2*rd_chan +: 2], rd_kelvin,
        rd_celsius, rd_sensor, rd_linear);

    // Setpoints of the strobed input, widened for the checks below.
    assign cur_hs = {high_sp[W*rd_chan+W-1], high_sp[W*rd_chan +: W]};
    assign cur_ls = {low_sp[W*rd_chan+W-1], low_sp[W*rd_chan +: W]};
    assign cur_db = {deadband[W*rd_chan+W-1], deadband[W*rd_chan +: W]};

    // ------------------------------------------------------------------
    // Per-input evaluators
    // ------------------------------------------------------------------

    // One evaluator per input, each with its own settings slice.
    generate
        for (genvar i = 0; i < N; i++) begin : g_chan
            alarm_eval_if #(.W(W)) eval_bus ();

            // Setpoints keep full word width, enough for five digits.
            assign eval_bus.valid    = rd_valid && (rd_chan == i);
            assign eval_bus.reading  = sel_value;
            assign eval_bus.en       = alarm_en[i];
            assign eval_bus.latch    = latch_en[i];
            assign eval_bus.high_sp  = high_sp[W*i +: W];
            assign eval_bus.low_sp   = low_sp[W*i +: W];
            assign eval_bus.deadband = deadband[W*i +: W];
            // No keypad lock qualifies the reset command.
            assign eval_bus.clr      = alarm_reset_cmd;
            assign high_alarm[i]     = eval_bus.high;
            assign low_alarm[i]      = eval_bus.low;

            alarm_channel #(.W(W)) u_chan (
                .core_clk (core_clk),
                .reset    (reset),
                .bus      (eval_bus)
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Summary of alarm state
    // ------------------------------------------------------------------

    // Every input counts, whatever the display shows.
    assign active      = high_alarm | low_alarm;
    assign any_active  = |active;
    assign any_enabled = |alarm_en;

    // ------------------------------------------------------------------
    // Flash timing
    // ------------------------------------------------------------------

    // Free-running half-period counter for all flashing indicators.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flash_cnt_q <= 32'h0;
        end else if (flash_cnt_q >= 32'(FLASH_CYCLES - 1)) begin
            flash_cnt_q <= 32'h0;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
        end
    end

    // Flash phase toggles at the end of each half period.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flash_phase_q <= `ALM_FLAG_RST;
        end else if (flash_cnt_q >= 32'(FLASH_CYCLES - 1)) begin
            flash_phase_q <= ~flash_phase_q;
        end
    end

    // ------------------------------------------------------------------
    // Indicators and beeper
    // ------------------------------------------------------------------

    // Display locations blink only for inputs in alarm.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            loc_flash_q <= '0;
        end else begin
            loc_flash_q <= active & {N{flash_phase_q}};
        end
    end

    // Annunciator: dark, steady, or blinking.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            annun_q <= `ALM_FLAG_RST;
        end else begin
            annun_q <= any_enabled
                       & (any_active ? flash_phase_q : 1'b1);
        end
    end

    // Beeper follows any alarm only while the audible setting is on.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            beeper_q <= `ALM_FLAG_RST;
        end else begin
            beeper_q <= audible_en & any_active;
        end
    end

    assign loc_flash = loc_flash_q;
    assign annun_lit = annun_q;
    assign beeper    = beeper_q;

    // ------------------------------------------------------------------
    // Reset confirmation
    // ------------------------------------------------------------------

    // Shows the confirmation; a repeated command restarts the time.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            confirm_state_q <= alarm_pkg::CONFIRM_IDLE;
            confirm_cnt_q   <= 32'h0;
        end else begin
            case (confirm_state_q)
                alarm_pkg::CONFIRM_IDLE: begin
                    if (alarm_reset_cmd) begin
                        confirm_state_q <= alarm_pkg::CONFIRM_SHOW;
                        confirm_cnt_q   <= 32'h0;
                    end
                end
                alarm_pkg::CONFIRM_SHOW: begin
                    if (alarm_reset_cmd) begin
                        confirm_cnt_q <= 32'h0;
                    end else if (confirm_cnt_q >= 32'(CONFIRM_CYCLES-1)) begin
                        confirm_state_q <= alarm_pkg::CONFIRM_IDLE;
                    end else begin
                        confirm_cnt_q <= confirm_cnt_q + 32'h1;
                    end
                end
                default: begin
                    confirm_state_q <= alarm_pkg::CONFIRM_IDLE;
                end
            endcase
        end
    end

    assign reset_confirm = (confirm_state_q == alarm_pkg::CONFIRM_SHOW);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    // A disabled input shows no alarm one cycle later.
    property p_disabled_quiet;
        @(posedge core_clk) disable iff (reset)
        1'b1 |=> ((high_alarm | low_alarm) & ~$past(alarm_en)) == '0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("alarm active on a disabled input");

    // A reading above the high setpoint raises the high alarm.
    property p_high_set;
        @(posedge core_clk) disable iff (reset)
        rd_valid && alarm_en[rd_chan] && ($signed({sel_value[W-1], sel_value})
            > cur_hs) |=> high_alarm[$past(rd_chan)];
    endproperty
    a_high_set: assert property (p_high_set)
        else $error("high alarm missed a reading above setpoint");

    // A reading below the low setpoint raises the low alarm.
    property p_low_set;
        @(posedge core_clk) disable iff (reset)
        rd_valid && alarm_en[rd_chan] && ($signed({sel_value[W-1], sel_value})
            < cur_ls) |=> low_alarm[$past(rd_chan)];
    endproperty
    a_low_set: assert property (p_low_set)
        else $error("low alarm missed a reading below setpoint");

    // Non-latching high alarm releases at setpoint minus deadband.
    property p_high_release;
        @(posedge core_clk) disable iff (reset)
        rd_valid && alarm_en[rd_chan] && !latch_en[rd_chan]
            && ($signed({sel_value[W-1], sel_value}) <= cur_hs - cur_db)
            |=> !high_alarm[$past(rd_chan)];
    endproperty
    a_high_release: assert property (p_high_release)
        else $error("non-latching high alarm held past deadband");

    // Non-latching low alarm releases at setpoint plus deadband.
    property p_low_release;
        @(posedge core_clk) disable iff (reset)
        rd_valid && alarm_en[rd_chan] && !latch_en[rd_chan]
            && ($signed({sel_value[W-1], sel_value}) >= cur_ls + cur_db)
            |=> !low_alarm[$past(rd_chan)];
    endproperty
    a_low_release: assert property (p_low_release)
        else $error("non-latching low alarm held past deadband");

    // A latched high alarm survives cycles without a reset command.
    property p_latch_hold;
        @(posedge core_clk) disable iff (reset)
        !alarm_reset_cmd |=>
            (($past(high_alarm) & $past(latch_en) & $past(alarm_en))
             & ~high_alarm) == '0;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched high alarm dropped without reset");

    // Reset with no reading leaves non-latching high alarms unchanged.
    property p_reset_nonlatch;
        @(posedge core_clk) disable iff (reset)
        alarm_reset_cmd && !rd_valid |=>
            ((high_alarm ^ $past(high_alarm)) & ~$past(latch_en)
             & $past(alarm_en)) == '0;
    endproperty
    a_reset_nonlatch: assert property (p_reset_nonlatch)
        else $error("reset changed a non-latching alarm");

    // Reset with no reading clears every latched alarm.
    property p_reset_clears;
        @(posedge core_clk) disable iff (reset)
        alarm_reset_cmd && !rd_valid |=>
            ((high_alarm | low_alarm) & $past(latch_en)) == '0;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset left a latched alarm on");

    // Beeper matches the audible setting and the alarm summary.
    property p_beeper;
        @(posedge core_clk) disable iff (reset)
        1'b1 |=> beeper == ($past(audible_en) && $past(any_active));
    endproperty
    a_beeper: assert property (p_beeper)
        else $error("beeper disagrees with alarm state");

    // Annunciator is steady when enabled and nothing is active.
    property p_annun_steady;
        @(posedge core_clk) disable iff (reset)
        any_enabled && !any_active |=> annun_lit;
    endproperty
    a_annun_steady: assert property (p_annun_steady)
        else $error("annunciator dark while alarms enabled");

    // Annunciator is dark when no input has alarms enabled.
    property p_annun_dark;
        @(posedge core_clk) disable iff (reset)
        !any_enabled |=> !annun_lit;
    endproperty
    a_annun_dark: assert property (p_annun_dark)
        else $error("annunciator lit with no alarm enabled");

    // Location flashing appears only on inputs in alarm.
    property p_loc_flash;
        @(posedge core_clk) disable iff (reset)
        1'b1 |=> (loc_flash & ~$past(active)) == '0;
    endproperty
    a_loc_flash: assert property (p_loc_flash)
        else $error("location flashing without an alarm");

    // The confirmation shows for at least eight cycles after a reset.
    sequence s_reset_cmd;
        alarm_reset_cmd;
    endsequence

    sequence s_confirm_hold;
        reset_confirm [*8];
    endsequence

    property p_confirm;
        @(posedge core_clk) disable iff (reset)
        s_reset_cmd |=> s_confirm_hold;
    endproperty
    a_confirm: assert property (p_confirm)
        else $error("reset confirmation missing or too short");

endmodule : input_alarm_monitor

// [sim/input_alarm_monitor_test.sv]
// Purpose: Random self-checking bench for the alarm monitor.
// Assumes: Short flash and confirmation times.
// Notes:   A bit-level model tracks every alarm.
`timescale 1ns/1ps

module input_alarm_monitor_test;
    localparam int CONF = 8;
    localparam int FLASH = 4;
    logic               core_clk, reset, req, aud, rcmd, rv;
    logic               annun, beep, conf, ph, pp;
    logic [2:0]         ch, rch;
    logic signed [31:0] val, rk, rc, rs, rl;
    logic [7:0]         en, lt, ha, la, lf, mh, ml;
    logic [15:0]        src;
    logic [255:0]       hs, ls, db;
    int                 errors, check_count, n, r, d, fc;

    reading_source src_m (.req(req), .chan(ch), .val(val), .rd_valid(rv),
        .rd_chan(rch), .rd_kelvin(rk), .rd_celsius(rc), .rd_sensor(rs),
        .rd_linear(rl));
    input_alarm_monitor #(.FLASH_CYCLES(FLASH), .CONFIRM_CYCLES(CONF)) dut (
        .core_clk(core_clk), .reset(reset), .rd_valid(rv), .rd_chan(rch),
        .rd_kelvin(rk), .rd_celsius(rc), .rd_sensor(rs), .rd_linear(rl),
        .alarm_en(en), .latch_en(lt), .src_sel(src), .high_sp(hs),
        .low_sp(ls), .deadband(db), .audible_en(aud),
        .alarm_reset_cmd(rcmd), .high_alarm(ha), .low_alarm(la),
        .loc_flash(lf), .annun_lit(annun), .beeper(beep),
        .reset_confirm(conf));

    // -----------------------------------------------------------------
    // Checking tasks
    // -----------------------------------------------------------------
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : cmp

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // Sends one reading, then checks alarms and the follow-on drives.
    task automatic strobe(int c, int v);
        case (src[2*c +: 2])
            2'h0: r = v;
            2'h1: r = v - 10;
            2'h2: r = v + 3;
            default: r = 2 * v;
        endcase
        d = (mh[c] && !lt[c]) ? $signed(db[32*c +: 32]) : 0;
        mh[c] = en[c] && (r > $signed(hs[32*c +: 32]) - d || lt[c] && mh[c]);
        d = (ml[c] && !lt[c]) ? $signed(db[32*c +: 32]) : 0;
        ml[c] = en[c] && (r < $signed(ls[32*c +: 32]) + d || lt[c] && ml[c]);
        ch = c[2:0];
        val = v;
        req = 1'b1;
        @(posedge core_clk);
        #1 req = 1'b0;
        pp = ph;
        cmp("high", mh, ha);
        cmp("low", ml, la);
        @(posedge core_clk);
        #1 cmp("beeper", {7'h0, aud && |(mh | ml)}, {7'h0, beep});
        cmp("flash", (mh | ml) & {8{pp}}, lf);
        r = |en && ((mh | ml) == 8'h0 || pp);
        cmp("annun", {7'h0, r[0]}, {7'h0, annun});
    endtask : strobe

    // Reprograms one input; a disabled input drops its alarms.
    task automatic reconf(int c);
        en[c] = ($urandom % 4) != 0;
        lt[c] = 1'($urandom);
        src[2*c +: 2] = 2'($urandom);
        hs[32*c +: 32] = 20 + $urandom % 10;
        ls[32*c +: 32] = 5 + $urandom % 10;
        db[32*c +: 32] = $urandom % 4;
        aud = 1'($urandom);
        mh[c] = mh[c] & en[c];
        ml[c] = ml[c] & en[c];
        @(posedge core_clk);
        #1 cmp("high", mh, ha);
        cmp("low", ml, la);
    endtask : reconf

    // Issues an alarm reset; only latched alarms clear.
    task automatic alarm_reset;
        rcmd = 1'b1;
        mh = mh & ~lt;
        ml = ml & ~lt;
        @(posedge core_clk);
        #1 rcmd = 1'b0;
        cmp("high", mh, ha);
        cmp("low", ml, la);
        cmp("confirm", 8'h1, {7'h0, conf});
        @(posedge core_clk);
        #1 cmp("confirm", 8'h1, {7'h0, conf});
    endtask : alarm_reset

    // Free-running core clock.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Flash phase model: starts low after reset, flips every half period.
    always @(posedge core_clk) begin
        if (reset) begin
            fc <= 0;
            ph <= 1'b0;
        end else if (fc == FLASH - 1) begin
            fc <= 0;
            ph <= ~ph;
        end else begin
            fc <= fc + 1;
        end
    end

    // Hang guard.
    initial begin
        #200000;
        errors++;
        final_report();
    end

    // Main sequence.
    initial begin
        {reset, req, rcmd, aud, ch, val, en, lt, src} = {1'b1, 70'h0};
        {hs, ls, db, mh, ml, errors, check_count} = '0;
        void'($urandom(32'hd336e388));
        repeat (16) @(posedge core_clk);
        #1 reset = 1'b0;
        @(posedge core_clk);
        #1 cmp("annun", 8'h0, {7'h0, annun});
        for (int i = 0; i < 8; i++)
            reconf(i);
        for (int i = 0; i < 400; i++) begin
            n = $urandom % 8;
            if (n < 6)
                strobe($urandom % 8, $urandom % 41);
            else if (n == 6)
                reconf($urandom % 8);
            else
                alarm_reset();
        end
        $display("test random done");
        alarm_reset();
        n = 2;
        while (conf === 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1 n++;
        end
        cmp("confirm len", 8'h1, {7'h0, n >= CONF && n <= CONF+1});
        $display("test confirm done");
        final_report();
    end
endmodule : input_alarm_monitor_test

// [sim/reading_source.sv]
// Purpose: Reading path model that feeds one strobe at a time.
// Assumes: The bench raises req just after an edge for one cycle.
// Notes:   Idle reading lines show the inverse of the held value.
`timescale 1ns/1ps

module reading_source (
    input  wire logic               req,
    input  wire logic [2:0]         chan,
    input  wire logic signed [31:0] val,
    output logic                    rd_valid,
    output logic [2:0]              rd_chan,
    output logic signed [31:0]      rd_kelvin,
    output logic signed [31:0]      rd_celsius,
    output logic signed [31:0]      rd_sensor,
    output logic signed [31:0]      rd_linear
);
    // Every source is a fixed offset or a doubling of one reading, so sources differ except at readings -10, 0 and 3.
    always_comb begin
        rd_valid   = req;
        rd_chan    = req ? chan : ~chan;
        rd_kelvin  = req ? val : ~val;
        rd_celsius = req ? val - 10 : ~val;
        rd_sensor  = req ? val + 3 : ~val;
        rd_linear  = req ? 2 * val : ~val;
    end
endmodule : reading_source
